/* File: hw/scdla_pkg.sv */
// Constants, types and field layout of the speed command, duty map
// and lead angle block. Assumes one 10 MHz clock and an APB host.
// Function
// - Valid pulses after silence start the motor
// - Highs of 0.2 us or less ignored
// - Low for 2.5 ms means command absent
// - Hold duty 510 ms, then stop
// - Map has adjustable low and mid points
// - Mid point applies at 50% command
// - Point settings give duty in 1/128 steps
// - Knee setting spans 0% to 50% command
// - Policy high holds low point below knee; mid point once knee is at 50%
// - Policy middle ramps knee duty to zero
// - Policy low forces zero below knee
// - Startup uses 120 degrees, no lead
// - Sensorless drive uses 150 degrees, selected lead
// - Bands 100 Hz low, else 200 Hz
// - Soft switching stages duty at commutation
// - Levels 0..8; 0,1,2 fixed angles
// - Levels 3..8 follow speed band table
// - Six bands span 600 Hz or 1.2 kHz
package scdla_pkg;
  localparam int          CLK_HZ        = 10_000_000;
  localparam int          MIN_HIGH_NS   = 200;
  localparam int          HIGH_MIN_CYC  =
    (MIN_HIGH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int          ABSENT_US     = 2500;
  localparam int          ABSENT_CYC    =
    ABSENT_US * (CLK_HZ / 1_000_000);
  localparam int          HOLD_MS       = 510;
  localparam int          HOLD_CYC      = HOLD_MS * (CLK_HZ / 1000);
  localparam logic [7:0]  DUTY_FULL     = 8'h80;
  localparam logic [7:0]  MID_CMD_DUTY  = 8'h40;
  localparam logic [6:0]  CODE_TOP      = 7'h7F;
  localparam logic [10:0] BAND_LOW_HZ   = 11'h064;
  localparam logic [10:0] BAND_HIGH_HZ  = 11'h0C8;
  localparam logic [2:0]  LAST_BAND     = 3'h5;
  localparam logic [2:0]  LEAD_MAX      = 3'h4;
  localparam logic [3:0]  LEVEL_MAX     = 4'h8;
  localparam logic [2:0]  SOFT_STAGES   = 3'h4;
  localparam logic [7:0]  OFF_CTRL      = 8'h00;
  localparam logic [7:0]  OFF_STATUS    = 8'h04;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam int          CTRL_KNEE_LSB = 0;
  localparam int          CTRL_LOW_LSB  = 8;
  localparam int          CTRL_MID_LSB  = 16;
  localparam int          CTRL_POL_LSB  = 24;
  localparam int          CTRL_RNG_LSB  = 26;
  localparam int          CTRL_LVL_LSB  = 28;
  // Three-level selects; open reads as middle
  localparam logic [1:0]  SEL_LOW       = 2'h0;
  localparam logic [1:0]  SEL_MID       = 2'h1;
  localparam logic [1:0]  SEL_HIGH      = 2'h2;

  typedef enum logic {ST_STOP, ST_RUN} scdla_state_t;

  typedef struct packed {
    logic [3:0] lead_angle_setting;
    logic [1:0] speed_range_select;
    logic [1:0] below_knee_policy;
    logic       pad2;
    logic [6:0] mid_point_duty_setting;
    logic       pad1;
    logic [6:0] low_point_duty_setting;
    logic       pad0;
    logic [6:0] knee_setting;
  } scdla_cfg_t;

  typedef struct packed {
    logic [9:0] pad;
    logic       cmd_absent;
    logic       motor_run;
    logic       comm_150;
    logic [2:0] lead_angle;
    logic [7:0] out_duty;
    logic [7:0] cmd_duty;
  } scdla_stat_t;
endpackage

/* File: hw/scdla_top.sv */
// Speed command qualifier, duty hold, duty map and lead angle select.
// Assumes speed_cmd_in is an asynchronous pin, and that the motor
// logic supplies mode, commutation edges and electrical speed on pclk.
`timescale 1ns/10ps
`default_nettype none
module scdla_top
  import scdla_pkg::*;
#(
  parameter int ABSENT_CYCLES = ABSENT_CYC,
  parameter int HOLD_CYCLES   = HOLD_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        speed_cmd_in,
  input  wire logic        sensorless_mode,
  input  wire logic        comm_edge,
  input  wire logic [10:0] elec_freq_hz,
  output logic             start_pulse,
  output logic             motor_run,
  output logic [7:0]       out_duty,
  output logic [2:0]       lead_angle,
  output logic             comm_150,
  output logic             soft_active
);

  // Setting code to output duty: end code saturates at full scale
  function automatic logic [7:0] pt_duty(input logic [6:0] c);
    pt_duty = (c == CODE_TOP) ? DUTY_FULL : {1'b0, c};
  endfunction

  // Linear step from y0 toward y1 over span; falling pair holds y0
  function automatic logic [7:0] interp(input logic [7:0] y0,
                                        input logic [7:0] y1,
                                        input logic [7:0] dx,
                                        input logic [7:0] span);
    logic [15:0] prod;
    logic [15:0] q;
    prod = {8'h00, y1 - y0} * {8'h00, dx};
    q    = (span == 8'h00) ? 16'h0000 : prod / {8'h00, span};
    interp = (y1 < y0) ? y0 : y0 + q[7:0];
  endfunction

  // Lead angle in 3.75 degree units from level and speed band
  function automatic logic [2:0] lead_lut(input logic [3:0] lvl,
                                          input logic [2:0] band);
    logic [3:0] s;
    s = 4'h0;
    case (lvl)
      4'h0: lead_lut = 3'h0;
      4'h1: lead_lut = 3'h2;
      4'h2: lead_lut = 3'h4;
      4'h3: lead_lut = (band == 3'h0) ? 3'h0 :
                       (band == 3'h1) ? 3'h2 : 3'h4;
      4'h4: lead_lut = (band == 3'h0) ? 3'h2 : 3'h4;
      default: begin
        s = {1'b0, band} + lvl - 4'h5;
        lead_lut = (s > {1'b0, LEAD_MAX}) ? LEAD_MAX : s[2:0];
      end
    endcase
  endfunction

  // APB register file
  scdla_cfg_t  cfg;
  scdla_stat_t stat;
  wire         acc     = psel && penable;
  wire         hit_ctl = (paddr == OFF_CTRL);
  wire         hit_st  = (paddr == OFF_STATUS);
  wire         bad     = !(hit_ctl || hit_st);
  assign pready  = 1'b1; // zero wait state slave
  assign pslverr = acc && bad;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= scdla_cfg_t'(CTRL_RESET);
    end else if (acc && pwrite && hit_ctl) begin
      cfg <= scdla_cfg_t'(pwdata);
    end
  end

  // Read data registered off the setup phase so it is stable at access
  wire [31:0] rd_mux = hit_ctl ? 32'(cfg) :
                       hit_st  ? 32'(stat) : 32'h0000_0000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // Pin synchroniser; only s_cmd and s_d are read by logic
  logic sync1;
  logic s_cmd;
  logic s_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 1'b0;
      s_cmd <= 1'b0;
      s_d   <= 1'b0;
    end else begin
      sync1 <= speed_cmd_in;
      s_cmd <= sync1;
      s_d   <= s_cmd;
    end
  end

  // Glitch filter: a high run must outlast the minimum width
  logic [1:0]  hi_run;
  logic [23:0] hi_len;
  logic [23:0] hi_last;
  logic [23:0] lo_cnt;
  logic [23:0] per_cnt;
  logic        hi_ok;
  logic        have_edge;
  logic        cmd_absent;
  wire q_rise = s_cmd && (hi_run == 2'(HIGH_MIN_CYC));
  wire q_fall = !s_cmd && s_d && hi_ok;
  wire absent_hit = !s_cmd && (lo_cnt == 24'(ABSENT_CYCLES - 1));
  // Steady high never makes edges, so it reads as full duty
  wire full_hit = s_cmd && (hi_len == 24'(ABSENT_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_run <= 2'h0;
      hi_ok  <= 1'b0;
    end else if (!s_cmd) begin
      hi_run <= 2'h0;
      hi_ok  <= 1'b0;
    end else begin
      if (hi_run != 2'h3) hi_run <= hi_run + 2'h1;
      if (q_rise) hi_ok <= 1'b1;
    end
  end

  // High width, low run and period counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_len  <= 24'h000000;
      hi_last <= 24'h000000;
      lo_cnt  <= 24'h000000;
      per_cnt <= 24'h000000;
    end else begin
      hi_len  <= (s_cmd && !full_hit) ? hi_len + 24'h1 : 24'h0;
      if (q_fall) hi_last <= hi_len;
      if (s_cmd && hi_ok) lo_cnt <= 24'h0;
      else if (!absent_hit) lo_cnt <= lo_cnt + 24'h1;
      per_cnt <= q_rise ? 24'h1 : per_cnt + 24'h1;
    end
  end

  // Command presence: silence marks absent, a valid rise clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_absent <= 1'b1;
      have_edge  <= 1'b0;
    end else if (absent_hit) begin
      cmd_absent <= 1'b1;
      have_edge  <= 1'b0;
    end else if (q_rise) begin
      cmd_absent <= 1'b0;
      have_edge  <= 1'b1;
    end
  end

  // Duty of the previous pulse in 1/128 steps
  wire [31:0] num  = {1'b0, hi_last, 7'h00};
  wire [31:0] quot = num / {8'h00, per_cnt};
  wire [7:0]  meas = (quot > {24'h0, DUTY_FULL}) ? DUTY_FULL
                                                 : quot[7:0];
  wire new_duty = (q_rise && have_edge) || full_hit;
  wire [7:0] new_val = full_hit ? DUTY_FULL : meas;
  // A zero duty is a stop request, so it never refreshes the hold
  wire reload = new_duty && (new_val != 8'h00);

  // Duty hold and run state
  logic [7:0]   cmd_duty;
  logic [23:0]  hold_cnt;
  scdla_state_t state;
  scdla_state_t next_state;
  wire hold_end = (hold_cnt == 24'h1) && !reload;

  always_comb begin
    next_state = state;
    case (state)
      ST_STOP: if (reload) next_state = ST_RUN;
      ST_RUN:  if (hold_end) next_state = ST_STOP;
      default: next_state = ST_STOP;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= ST_STOP;
      cmd_duty    <= 8'h00;
      hold_cnt    <= 24'h0;
      start_pulse <= 1'b0;
    end else begin
      state       <= next_state;
      start_pulse <= (state == ST_STOP) && reload;
      if (reload) begin
        cmd_duty <= new_val;
        hold_cnt <= 24'(HOLD_CYCLES);
      end else if (hold_cnt != 24'h0) begin
        hold_cnt <= hold_cnt - 24'h1;
      end
    end
  end
  assign motor_run = (state == ST_RUN);

  // Map points from setting codes
  wire [7:0] lo_pt = pt_duty(cfg.low_point_duty_setting);
  wire [7:0] mi_pt = pt_duty(cfg.mid_point_duty_setting);
  // Knee spans half the command range
  wire [7:0] knee  = pt_duty(cfg.knee_setting) >> 1;
  wire [1:0] pol   = cfg.below_knee_policy;
  wire [7:0] x     = cmd_duty;

  // Output duty at the knee, then the region picked by command
  wire [7:0] knee_out = (knee >= MID_CMD_DUTY) ? mi_pt : lo_pt;
  wire [7:0] below =
    (pol == SEL_HIGH) ? knee_out :
    (pol == SEL_LOW)  ? 8'h00 :
    interp(8'h00, knee_out, x, knee);
  wire [7:0] mid_seg = interp(lo_pt, mi_pt, x - knee,
                              MID_CMD_DUTY - knee);
  wire [7:0] top_seg = interp(mi_pt, DUTY_FULL, x - MID_CMD_DUTY,
                              MID_CMD_DUTY);
  wire [7:0] map_duty = (x <= knee)         ? below :
                        (x <= MID_CMD_DUTY) ? mid_seg :
                        top_seg;

  // Lead angle band from electrical speed
  wire [10:0] band_w = (cfg.speed_range_select == SEL_LOW)
                       ? BAND_LOW_HZ : BAND_HIGH_HZ;
  wire [10:0] band_q = elec_freq_hz / band_w;
  wire [2:0]  band   = (band_q > {8'h00, LAST_BAND}) ? LAST_BAND
                                                     : band_q[2:0];
  wire [3:0]  lvl    = (cfg.lead_angle_setting > LEVEL_MAX)
                       ? LEVEL_MAX : cfg.lead_angle_setting;
  // Levels and bands per table; six bands cover the full range
  wire [2:0]  lead_sel = lead_lut(lvl, band);

  // Commutation shape: forced startup ignores the lead setting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lead_angle <= 3'h0;
      comm_150   <= 1'b0;
    end else if (!sensorless_mode) begin
      lead_angle <= 3'h0;
      comm_150   <= 1'b0;
    end else begin
      lead_angle <= lead_sel;
      comm_150   <= 1'b1;
    end
  end
  assign soft_active = comm_150;

  // Soft switching ramps duty back in stages after each edge
  logic [2:0]  stage;
  wire  [10:0] scaled = {3'h0, map_duty} * {8'h00, stage};
  wire  [7:0]  staged = (stage == 3'h0) ? map_duty : scaled[9:2];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage <= 3'h0;
    end else if (soft_active && comm_edge) begin
      stage <= 3'h1;
    end else if (stage != 3'h0) begin
      stage <= (stage == SOFT_STAGES - 3'h1) ? 3'h0 : stage + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_duty <= 8'h00;
    end else begin
      out_duty <= motor_run ? staged : 8'h00;
    end
  end

  // Status word
  always_comb begin
    stat            = '0;
    stat.cmd_duty   = cmd_duty;
    stat.out_duty   = out_duty;
    stat.lead_angle = lead_angle;
    stat.comm_150   = comm_150;
    stat.motor_run  = motor_run;
    stat.cmd_absent = cmd_absent;
  end

  // Three high samples in a row before a rise is taken
  sequence s_three_high;
    s_cmd ##1 s_cmd ##1 s_cmd;
  endsequence
  property p_glitch;
    @(posedge pclk) disable iff (!presetn)
    q_rise |-> s_cmd && $past(s_cmd) && $past(s_cmd, 2);
  endproperty
  a_glitch: assert property (p_glitch)
    else $error("short high taken as command");
  property p_glitch_hold;
    @(posedge pclk) disable iff (!presetn)
    (!s_cmd ##1 s_three_high) |-> q_rise ##1 hi_ok;
  endproperty
  a_glitch_hold: assert property (p_glitch_hold)
    else $error("valid high not qualified");

  property p_absent;
    @(posedge pclk) disable iff (!presetn)
    absent_hit |=> cmd_absent && !have_edge;
  endproperty
  a_absent: assert property (p_absent)
    else $error("long low not seen as absent");

  property p_start;
    @(posedge pclk) disable iff (!presetn)
    (state == ST_STOP) && reload |=> start_pulse && motor_run
      ##1 !start_pulse;
  endproperty
  a_start: assert property (p_start)
    else $error("start missing after valid command");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    motor_run && hold_end |=> !motor_run && out_duty == 8'h00 ||
      !motor_run ##1 out_duty == 8'h00;
  endproperty
  a_hold: assert property (p_hold)
    else $error("run did not end after hold");

  property p_reload;
    @(posedge pclk) disable iff (!presetn)
    reload |=> hold_cnt == 24'(HOLD_CYCLES) && motor_run;
  endproperty
  a_reload: assert property (p_reload)
    else $error("hold not restarted");

  property p_mid;
    @(posedge pclk) disable iff (!presetn)
    x == MID_CMD_DUTY && knee < MID_CMD_DUTY |-> map_duty == mi_pt;
  endproperty
  a_mid: assert property (p_mid)
    else $error("mid point duty wrong");

  property p_pol_high;
    @(posedge pclk) disable iff (!presetn)
    pol == SEL_HIGH && x <= knee && knee < MID_CMD_DUTY
      |-> map_duty == lo_pt;
  endproperty
  a_pol_high: assert property (p_pol_high)
    else $error("high policy not holding low point");

  property p_pol_low;
    @(posedge pclk) disable iff (!presetn)
    pol == SEL_LOW && x <= knee |-> map_duty == 8'h00;
  endproperty
  a_pol_low: assert property (p_pol_low)
    else $error("low policy not zero");

  property p_forced;
    @(posedge pclk) disable iff (!presetn)
    !sensorless_mode |=> lead_angle == 3'h0 && !comm_150;
  endproperty
  a_forced: assert property (p_forced)
    else $error("startup shape not plain");

  property p_fixed_lvl;
    @(posedge pclk) disable iff (!presetn)
    sensorless_mode && lvl == 4'h1 |=> lead_angle == 3'h2;
  endproperty
  a_fixed_lvl: assert property (p_fixed_lvl)
    else $error("level one lead not 7.5 degrees");

endmodule
`default_nettype wire

/* File: test/scdla_host.sv */
// Host model: a PWM speed command, period and high time in clocks.
// Assumes the device clock; glitch adds a 2-cycle high in the low phase.
`timescale 1ns/10ps
`default_nettype none
module scdla_host (
  input  wire logic        pclk,
  input  wire logic        run,
  input  wire logic        glitch,
  input  wire logic [15:0] period,
  input  wire logic [15:0] high,
  output logic             speed_cmd_in
);
  logic [15:0] cnt = 16'h0000;
  initial speed_cmd_in = 1'b0;
  // Bench keeps the period at 128 clocks, inside the host's rate range
  always @(posedge pclk) begin
    cnt <= (!run || cnt >= period - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
    speed_cmd_in <= run && (cnt < high || (glitch &&
      cnt >= period - 16'h0008 && cnt < period - 16'h0006));
  end
endmodule
`default_nettype wire

/* File: test/scdla_top_bench.sv */
// Bench for the speed command, duty map and lead angle block.
// Assumes the host model; every result passes through one note queue.
`timescale 1ns/10ps
`default_nettype none
module scdla_top_bench;
  import scdla_pkg::*;
  localparam int AB = 200;
  localparam int HO = 2000;
  logic        pclk = 1'b0, presetn = 1'b0, comm_edge = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        sensorless_mode = 1'b0, run = 1'b0, glitch = 1'b1;
  logic [7:0]  paddr = 8'h00, out_duty;
  logic [31:0] pwdata = 32'h0, prdata, rd, seen, e, m;
  logic [31:0] seed = 32'h6D46, w;
  logic        pready, pslverr, speed_cmd_in, start_pulse, motor_run;
  logic        comm_150, soft_active, er;
  logic [10:0] elec_freq_hz = 11'h000;
  logic [2:0]  lead_angle;
  logic [15:0] period = 16'h0080, high = 16'h0010;
  logic [7:0]  s[6];
  logic [31:0] exp_q[$], msk_q[$];
  string       nm_q[$], nm;
  int          n_fail = 0, tests_run = 0, cyc = 0, n_start = 0;
  int          nseen = 0, st, i;
  int          xs[5] = '{16, 32, 48, 64, 96};

  scdla_top #(.ABSENT_CYCLES(AB), .HOLD_CYCLES(HO)) scdla_top_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .speed_cmd_in, .sensorless_mode,
    .comm_edge, .elec_freq_hz, .start_pulse, .motor_run, .out_duty,
    .lead_angle, .comm_150, .soft_active);
  scdla_host scdla_host_i (.pclk, .run, .glitch, .period, .high,
    .speed_cmd_in);

  always #50 pclk = ~pclk;

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {1'b0, v[31:1]} ^ (v[0] ? 32'hA300_0000 : 32'h0);
  endfunction
  // Expected map; cases are picked so every division is exact
  function automatic int map(input int x, k, lo, mi, p);
    if (x > 64) return mi + (128 - mi) * (x - 64) / 64;
    if (x > k) return lo + (mi - lo) * (x - k) / (64 - k);
    if (p == 2) return lo;
    if (p == 0 || k == 0) return 0;
    return lo * x / k;
  endfunction
  // Lead in 3.75 degree units for a level and a speed band
  function automatic logic [2:0] lx(input int l, b);
    int v;
    l = l > 8 ? 8 : l;
    v = l < 3 ? 2 * l : l == 3 ? 2 * b : l == 4 ? 2 * b + 2 : b + l - 5;
    return v > 4 ? 3'h4 : 3'(v);
  endfunction

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Note the expectation, then hand the result to the watcher
  task automatic see(input string n, input logic [31:0] x, k, v);
    nm_q.push_back(n);
    exp_q.push_back(x & k);
    msk_q.push_back(k);
    seen = v;
    nseen++;
    #1;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [7:0] a,
                     input logic [31:0] x, k);
    apb(1'b0, a, 32'h0);
    see(n, x, k, rd);
  endtask
  task automatic cfg(input logic [6:0] k, l, md, input logic [1:0] p, r,
                     input logic [3:0] v);
    apb(1'b1, OFF_CTRL, {v, r, p, 1'b0, md, 1'b0, l, 1'b0, k});
  endtask

  // Watcher: oldest note against each result; also the hang limit
  always @(nseen) begin
    e = exp_q.pop_front();
    m = msk_q.pop_front();
    nm = nm_q.pop_front();
    tests_run++;
    if ((seen & m) !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, seen & m);
    end
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (start_pulse === 1'b1) n_start <= n_start + 1;
    if (cyc == 40000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk("ctrl rst", OFF_CTRL, CTRL_RESET, 32'hFFFF_FFFF);
    apb(1'b1, OFF_STATUS, 32'hFFFF_FFFF);
    chk("stat rst", OFF_STATUS, 32'h0020_0000, 32'hFFFF_FFFF);
    apb(1'b0, 8'h08, 32'h0);
    see("bad err", 32'h1, 32'h1, {31'h0, er});
    see("bad data", 32'h0, 32'hFFFF_FFFF, rd);
    // Random settings, low point kept at or under the mid point
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      w = (seed & 32'h7F00_7F7F) | 32'h007F_0000;
      apb(1'b1, OFF_CTRL, w);
      chk("ctrl", OFF_CTRL, w, 32'hFFFF_FFFF);
    end
    cfg(7'h00, 7'h00, 7'h00, SEL_LOW, SEL_HIGH, 4'h8);
    elec_freq_hz <= 11'h44C;
    run <= 1'b1;
    repeat (600) @(posedge pclk);
    see("start", 32'h1, 32'hFF, n_start);
    chk("forced", OFF_STATUS, 32'h0, 32'h000F_0000);
    sensorless_mode <= 1'b1;
    // Level nine checks the clamp to the top level
    for (int lv = 0; lv <= 9; lv++)
      for (int r = 0; r < 4; r++)
        for (int b = 0; b < 6; b++) begin
          seed = lfsr(seed);
          st = r == 0 ? 100 : 200;
          cfg(7'h00, 7'h00, 7'h00, SEL_LOW, 2'(r), 4'(lv));
          elec_freq_hz <= 11'(b * st + seed % st);
          chk("lead", OFF_STATUS, {12'h0, 1'b1, lx(lv, b), 16'h0},
              32'h000F_0000);
        end
    // Knee 32, low point 32, mid point 64; glitches run throughout
    foreach (xs[j])
      for (int p = 0; p < 4; p++) begin
        cfg(7'h40, 7'h20, 7'h40, 2'(p), SEL_LOW, 4'h0);
        high <= 16'(xs[j]);
        repeat (384) @(posedge pclk);
        chk("duty", OFF_STATUS, {11'h0, 1'b1, 4'h0,
            8'(map(xs[j], 32, 32, 64, p == 3 ? 1 : p)), 8'(xs[j])},
            32'h0010_FFFF);
      end
    comm_edge <= 1'b1;
    @(posedge pclk);
    comm_edge <= 1'b0;
    for (i = 0; i < 6; i++) begin
      @(posedge pclk);
      #1 s[i] = out_duty;
    end
    // Quarter steps from the edge, then full duty holds
    for (int k = 0; k < 5; k++)
      see("soft", 24 * (k < 4 ? k + 1 : 4), 32'hFF, s[k]);
    see("soft pin", 32'h1, 32'h1, {31'h0, soft_active});
    run <= 1'b0;
    repeat (HO - 180) @(posedge pclk);
    chk("absent", OFF_STATUS, 32'h0030_0000, 32'h0030_0000);
    repeat (200) @(posedge pclk);
    // Sensorless mode is still on, so the shape bit reads one
    chk("stop", OFF_STATUS, 32'h0028_0000, 32'h003F_FF00);
    see("run pin", 32'h0, 32'h1, {31'h0, motor_run});
    run <= 1'b1;
    repeat (600) @(posedge pclk);
    see("restart", 32'h2, 32'hFF, n_start);
    give_verdict();
  end
endmodule
`default_nettype wire
